/* File: grfi_mac_edge.sv */
// GMII edge and receive FIFO write side of the MAC
`timescale 1ns/1ps
`default_nettype none
module grfi_mac_edge
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	input wire logic tx_err_in,
	output logic [7:0] txd_out,
	output logic tx_en_out,
	output logic tx_er_out,
	input wire logic [7:0] rxd_in,
	input wire logic rx_dv_in,
	input wire logic rx_er_in,
	input wire logic rx_fifo_full_in,
	input wire logic drop_pkts_in,
	output logic rx_write_out,
	output logic [7:0] rx_data_out,
	output logic rx_eof_out,
	output logic rx_error_out,
	output logic rx_fifo_error_out,
	output logic [31:0] rx_stat_out,
	output logic rx_stat_en_out
);
	// ==========================================================
	// Functions
	function automatic logic is_byte(input logic [7:0] b, input logic [7:0] ref_b);
		is_byte = (b == ref_b);
	endfunction : is_byte

	// ==========================================================
	// Transmit side
	grfi_pkg::grfi_byte_t tx_byte;
	assign tx_byte = '{data: tx_data_in, valid: tx_valid_in, err: tx_err_in};

	grfi_gmii_tx u_tx
	(
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.tx_byte_in(tx_byte),
		.txd_out(txd_out),
		.tx_en_out(tx_en_out),
		.tx_er_out(tx_er_out)
	);

	// ==========================================================
	// Drop request synchroniser
	logic drop_sync;

	grfi_sync u_drop_sync
	(
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.async_in(drop_pkts_in),
		.sync_out(drop_sync)
	);

	// ==========================================================
	// Receive state
	grfi_pkg::grfi_state_t state_r;
	grfi_pkg::grfi_state_t state_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic err_r;
	logic err_nxt;
	logic ovf_r;
	logic ovf_nxt;
	logic drop_frame_r;
	logic drop_frame_nxt;
	logic rx_write_nxt;
	logic rx_eof_nxt;
	logic stat_en_nxt;
	grfi_pkg::grfi_stat_t stat_nxt;

	wire is_pre = rx_dv_in & is_byte(rxd_in, grfi_pkg::PREAMBLE_BYTE);
	wire is_sfd = rx_dv_in & is_byte(rxd_in, grfi_pkg::SFD_BYTE);
	// Full seen while a byte is on the bus means that byte is lost; no retry
	wire lost_byte = rx_fifo_full_in & rx_write_out;
	wire ovf_final = ovf_r | lost_byte;
	wire cnt_sat = (cnt_r == grfi_pkg::BYTE_CNT_MAX);
	wire frame_end = (state_r == grfi_pkg::ST_FRAME) & ~rx_dv_in;
	wire drop_end = (state_r == grfi_pkg::ST_SKIP) & ~rx_dv_in & drop_frame_r;

	grfi_pkg::grfi_stat_t frame_stat;
	grfi_pkg::grfi_stat_t drop_stat;
	assign frame_stat = '{byte_cnt: cnt_r, rsvd: 13'h0000, dropped: 1'b0, fifo_ovf: ovf_final, rx_err: err_r};
	assign drop_stat = '{byte_cnt: 16'h0000, rsvd: 13'h0000, dropped: 1'b1, fifo_ovf: 1'b0, rx_err: 1'b0};

	// ==========================================================
	// Next-state decode
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		err_nxt = err_r;
		ovf_nxt = ovf_r;
		drop_frame_nxt = drop_frame_r;
		unique case (state_r)
			grfi_pkg::ST_IDLE:
			begin
				if (is_pre)
					state_nxt = grfi_pkg::ST_PREAMBLE;
				else if (rx_dv_in)
					state_nxt = grfi_pkg::ST_SKIP;
			end
			grfi_pkg::ST_PREAMBLE:
			begin
				cnt_nxt = 16'h0000;
				err_nxt = 1'b0;
				ovf_nxt = 1'b0;
				drop_frame_nxt = 1'b0;
				if (!rx_dv_in)
					state_nxt = grfi_pkg::ST_IDLE;
				else if (is_sfd && drop_sync)
				begin
					// Decision is frozen per frame so a frame is never cut in half
					state_nxt = grfi_pkg::ST_SKIP;
					drop_frame_nxt = 1'b1;
				end
				else if (is_sfd)
					state_nxt = grfi_pkg::ST_FRAME;
				else if (!is_pre)
					state_nxt = grfi_pkg::ST_SKIP;
			end
			grfi_pkg::ST_FRAME:
			begin
				if (rx_dv_in)
				begin
					cnt_nxt = cnt_sat ? cnt_r : cnt_r + 16'h0001;
					err_nxt = err_r | rx_er_in;
					ovf_nxt = ovf_final;
				end
				else
					state_nxt = grfi_pkg::ST_IDLE;
			end
			grfi_pkg::ST_SKIP:
			begin
				if (!rx_dv_in)
				begin
					state_nxt = grfi_pkg::ST_IDLE;
					drop_frame_nxt = 1'b0;
				end
			end
		endcase
	end

	// Bytes only taken while valid; strobe held across the frame
	assign rx_write_nxt = (state_r == grfi_pkg::ST_FRAME) & rx_dv_in;
	assign rx_eof_nxt = frame_end;
	assign stat_en_nxt = frame_end | drop_end;
	assign stat_nxt = frame_end ? frame_stat : drop_stat;

	// ==========================================================
	// Registers, all on the receive clock
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			state_r <= grfi_pkg::ST_IDLE;
			cnt_r <= 16'h0000;
			err_r <= 1'b0;
			ovf_r <= 1'b0;
			drop_frame_r <= 1'b0;
			rx_write_out <= 1'b0;
			rx_data_out <= 8'h00;
			rx_eof_out <= 1'b0;
			rx_error_out <= 1'b0;
			rx_fifo_error_out <= 1'b0;
			rx_stat_out <= grfi_pkg::STAT_RESET;
			rx_stat_en_out <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			err_r <= err_nxt;
			ovf_r <= ovf_nxt;
			drop_frame_r <= drop_frame_nxt;
			rx_write_out <= rx_write_nxt;
			rx_data_out <= rx_write_nxt ? rxd_in : 8'h00;
			rx_eof_out <= rx_eof_nxt;
			rx_error_out <= frame_end & err_r;
			rx_fifo_error_out <= frame_end & ovf_final;
			rx_stat_en_out <= stat_en_nxt;
			rx_stat_out <= stat_en_nxt ? stat_nxt : grfi_pkg::STAT_RESET;
		end
	end

	// ==========================================================
	// Assertions
	property p_tx_data;
		@(posedge ref_clk_in) disable iff (srst_in)
		tx_en_out |-> txd_out == $past(tx_data_in);
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("tx data mismatch");

	property p_tx_en;
		@(posedge ref_clk_in) disable iff (srst_in)
		##1 tx_en_out == $past(tx_valid_in);
	endproperty
	a_tx_en: assert property (p_tx_en) else $error("tx enable not tied to valid");

	property p_tx_er;
		@(posedge ref_clk_in) disable iff (srst_in)
		tx_er_out |-> tx_en_out && $past(tx_err_in);
	endproperty
	a_tx_er: assert property (p_tx_er) else $error("tx error outside a sent byte");

	property p_wr_dv;
		@(posedge ref_clk_in) disable iff (srst_in)
		rx_write_out |-> $past(rx_dv_in) && rx_data_out == $past(rxd_in);
	endproperty
	a_wr_dv: assert property (p_wr_dv) else $error("write without valid receive byte");

	property p_sfd_write;
		@(posedge ref_clk_in) disable iff (srst_in)
		(state_r == grfi_pkg::ST_PREAMBLE && is_sfd && !drop_sync && rx_dv_in) ##1 rx_dv_in |=> rx_write_out;
	endproperty
	a_sfd_write: assert property (p_sfd_write) else $error("first byte after delimiter not written");

	property p_eof;
		@(posedge ref_clk_in) disable iff (srst_in)
		$fell(rx_write_out) |-> rx_eof_out;
	endproperty
	a_eof: assert property (p_eof) else $error("end of frame missing after last write");

	property p_eof_clean;
		@(posedge ref_clk_in) disable iff (srst_in)
		rx_eof_out |-> !rx_write_out && rx_stat_en_out;
	endproperty
	a_eof_clean: assert property (p_eof_clean) else $error("end of frame overlaps write");

	property p_err_qual;
		@(posedge ref_clk_in) disable iff (srst_in)
		(rx_error_out || rx_fifo_error_out) |-> rx_eof_out;
	endproperty
	a_err_qual: assert property (p_err_qual) else $error("error flag without end of frame");

	// ==========================================================
	// Assertion helper: full seen during any write of the current frame
	// Set wins over the clear, so a full on a write never slips past the flag
	logic full_seen_r;
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			full_seen_r <= 1'b0;
		else if (rx_write_out && rx_fifo_full_in)
			full_seen_r <= 1'b1;
		else if (rx_eof_out)
			full_seen_r <= 1'b0;
	end

	property p_fifo_err;
		@(posedge ref_clk_in) disable iff (srst_in)
		rx_eof_out |-> rx_fifo_error_out == full_seen_r;
	endproperty
	a_fifo_err: assert property (p_fifo_err) else $error("fifo error flag disagrees with full seen");

	property p_data_idle;
		@(posedge ref_clk_in) disable iff (srst_in)
		!rx_write_out |-> rx_data_out == 8'h00;
	endproperty
	a_data_idle: assert property (p_data_idle) else $error("fifo data not zero outside a write");

	property p_stat_idle;
		@(posedge ref_clk_in) disable iff (srst_in)
		!rx_stat_en_out |-> rx_stat_out == 32'h00000000;
	endproperty
	a_stat_idle: assert property (p_stat_idle) else $error("statistics vector not zero while unqualified");

	property p_tx_idle;
		@(posedge ref_clk_in) disable iff (srst_in)
		!tx_en_out |-> txd_out == 8'h00 && !tx_er_out;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx lines active without enable");

	property p_drop_stat;
		@(posedge ref_clk_in) disable iff (srst_in)
		drop_end |=> rx_stat_en_out && rx_stat_out[2] && !rx_eof_out;
	endproperty
	a_drop_stat: assert property (p_drop_stat) else $error("dropped frame not reported as dropped");

	property p_wr_hold;
		@(posedge ref_clk_in) disable iff (srst_in)
		(rx_write_out && state_r == grfi_pkg::ST_FRAME && rx_dv_in) |=> rx_write_out;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write strobe gap inside a frame");

	property p_stat_pulse;
		@(posedge ref_clk_in) disable iff (srst_in)
		rx_stat_en_out |=> !rx_stat_en_out;
	endproperty
	a_stat_pulse: assert property (p_stat_pulse) else $error("statistics strobe longer than one cycle");

	property p_drop;
		@(posedge ref_clk_in) disable iff (srst_in)
		drop_frame_r |-> !rx_write_out && !rx_eof_out;
	endproperty
	a_drop: assert property (p_drop) else $error("dropped frame reached the FIFO");

	property p_lost_flag;
		@(posedge ref_clk_in) disable iff (srst_in)
		(state_r == grfi_pkg::ST_FRAME && rx_dv_in && lost_byte) |=> ovf_r;
	endproperty
	a_lost_flag: assert property (p_lost_flag) else $error("lost byte not recorded");

	c_good_frame: cover property (@(posedge ref_clk_in) disable iff (srst_in) rx_eof_out && !rx_error_out);
	c_err_frame: cover property (@(posedge ref_clk_in) disable iff (srst_in) rx_eof_out && rx_error_out);
	c_ovf_frame: cover property (@(posedge ref_clk_in) disable iff (srst_in) rx_eof_out && rx_fifo_error_out);
	c_drop_frame: cover property (@(posedge ref_clk_in) disable iff (srst_in) drop_end);
	c_b2b_frame: cover property (@(posedge ref_clk_in) disable iff (srst_in) rx_eof_out ##3 rx_write_out);
endmodule : grfi_mac_edge
`default_nettype wire

/* File: grfi_pkg.sv */
// Package with constants and types for the GMII receive FIFO interface block
`default_nettype none
package grfi_pkg;
	// ==========================================================
	// Frame delimiters, synchroniser depth and byte counter limits
	localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
	localparam logic [7:0] SFD_BYTE = 8'hD5;
	localparam int SYNC_STAGES = 2;
	localparam int BYTE_CNT_W = 16;
	localparam logic [15:0] BYTE_CNT_MAX = 16'hFFFF;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {ST_IDLE, ST_PREAMBLE, ST_FRAME, ST_SKIP} grfi_state_t;
	typedef struct packed {
		logic [7:0] data;
		logic valid;
		logic err;
	} grfi_byte_t;
	typedef struct packed {
		logic [15:0] byte_cnt;
		logic [12:0] rsvd;
		logic dropped;
		logic fifo_ovf;
		logic rx_err;
	} grfi_stat_t;
	localparam grfi_stat_t STAT_RESET = '{byte_cnt: 16'h0000, rsvd: 13'h0000, dropped: 1'b0,
		fifo_ovf: 1'b0, rx_err: 1'b0};
endpackage : grfi_pkg
`default_nettype wire

/* File: grfi_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module grfi_sync
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r;
	// ==========================================================
	// First stage feeds only the second
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			meta_r <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : grfi_sync
`default_nettype wire

/* File: grfi_gmii_tx.sv */
// Registered GMII transmit driver
`timescale 1ns/1ps
`default_nettype none
module grfi_gmii_tx
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire grfi_pkg::grfi_byte_t tx_byte_in,
	output logic [7:0] txd_out,
	output logic tx_en_out,
	output logic tx_er_out
);
	// Error only qualifies a byte actually being sent
	wire tx_er_nxt = tx_byte_in.valid & tx_byte_in.err;
	// ==========================================================
	// Output registers
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			txd_out <= 8'h00;
			tx_en_out <= 1'b0;
			tx_er_out <= 1'b0;
		end
		else
		begin
			txd_out <= tx_byte_in.valid ? tx_byte_in.data : 8'h00;
			tx_en_out <= tx_byte_in.valid;
			tx_er_out <= tx_er_nxt;
		end
	end
endmodule : grfi_gmii_tx
`default_nettype wire

/* File: grfi_phy_model.sv */
// Behavioural GMII PHY and receive FIFO full source for the receive side
`timescale 1ns/1ps
`default_nettype none
module grfi_phy_model
(
	input wire logic ref_clk_in,
	output logic [7:0] rxd_out,
	output logic rx_dv_out,
	output logic rx_er_out,
	output logic fifo_full_out
);
	initial
	begin
		rxd_out = 8'h00;
		rx_dv_out = 1'b0;
		rx_er_out = 1'b0;
		fifo_full_out = 1'b0;
	end
	// ==========================================================
	// One wire cycle; idle data lines toggle so a stale byte never looks valid
	task automatic put(input logic dv, input logic [7:0] d, input logic er, input logic full);
	begin
		@(posedge ref_clk_in);
		#1;
		rx_dv_out = dv;
		rxd_out = dv ? d : ~rxd_out;
		rx_er_out = er;
		fifo_full_out = full;
	end
	endtask : put
	// ==========================================================
	// Full stays up one idle cycle so the last byte's write also sees it
	task automatic send(input int n, input int er_at, input logic full, input logic [7:0] lead);
		int i;
	begin
		put(1'b1, lead, 1'b0, 1'b0);
		put(1'b1, grfi_pkg::SFD_BYTE, 1'b0, 1'b0);
		for (i = 0; i < n; i++)
			put(1'b1, 8'h10 + 8'(i), i == er_at, full);
		put(1'b0, 8'h00, 1'b0, full);
	end
	endtask : send
endmodule : grfi_phy_model
`default_nettype wire

/* File: grfi_mac_edge_bench.sv */
// Self-checking bench for the MAC edge block
`timescale 1ns/1ps
`default_nettype none
`define GRFI_CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
	$display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module grfi_mac_edge_bench;
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] tx_data_in = 8'h00;
	logic tx_valid_in = 1'b0;
	logic tx_err_in = 1'b0;
	logic drop_pkts_in = 1'b0;
	logic [7:0] txd_out, rxd, rx_data_out;
	logic tx_en_out, tx_er_out, rx_dv, rx_er, full, rx_write_out, rx_eof_out, rx_error_out, rx_fifo_error_out;
	logic [31:0] rx_stat_out, stat_s;
	logic rx_stat_en_out, err_s, ferr_s, wr_d;
	logic [7:0] got_q[$];
	int fails = 0;
	int checks = 0;
	int eofs, stats, rises, i;
	always #2 ref_clk_in = ~ref_clk_in;
	grfi_phy_model i_grfi_phy_model (.ref_clk_in(ref_clk_in), .rxd_out(rxd), .rx_dv_out(rx_dv),
		.rx_er_out(rx_er), .fifo_full_out(full));
	grfi_mac_edge i_grfi_mac_edge (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .tx_data_in(tx_data_in),
		.tx_valid_in(tx_valid_in), .tx_err_in(tx_err_in), .txd_out(txd_out), .tx_en_out(tx_en_out),
		.tx_er_out(tx_er_out), .rxd_in(rxd), .rx_dv_in(rx_dv), .rx_er_in(rx_er), .rx_fifo_full_in(full),
		.drop_pkts_in(drop_pkts_in), .rx_write_out(rx_write_out), .rx_data_out(rx_data_out),
		.rx_eof_out(rx_eof_out), .rx_error_out(rx_error_out), .rx_fifo_error_out(rx_fifo_error_out),
		.rx_stat_out(rx_stat_out), .rx_stat_en_out(rx_stat_en_out));
	// ==========================================================
	// Receive FIFO side monitor
	always @(posedge ref_clk_in)
	begin
		if (rx_write_out === 1'b1)
			got_q.push_back(rx_data_out);
		if (rx_write_out === 1'b1 && wr_d !== 1'b1)
			rises++;
		wr_d = rx_write_out;
		if (rx_eof_out === 1'b1)
		begin
			eofs++;
			err_s = rx_error_out;
			ferr_s = rx_fifo_error_out;
		end
		if (rx_stat_en_out === 1'b1)
		begin
			stats++;
			stat_s = rx_stat_out;
		end
	end
	task automatic rx_frame(input int n, input int er_at, input logic fl, input logic [7:0] lead);
	begin
		got_q.delete();
		{eofs, stats, rises, err_s, ferr_s, stat_s} = '0;
		i_grfi_phy_model.send(n, er_at, fl, lead);
		repeat (4) @(posedge ref_clk_in);
		#1;
	end
	endtask : rx_frame
	// ==========================================================
	// Scenarios
	task automatic t_tx;
	begin
		{tx_valid_in, tx_data_in, tx_err_in} = {1'b1, 8'hA5, 1'b0};
		@(posedge ref_clk_in);
		#1;
		`GRFI_CHK("txd", 8'hA5, txd_out)
		`GRFI_CHK("tx_en", 1'b1, tx_en_out)
		{tx_data_in, tx_err_in} = {8'h3C, 1'b1};
		@(posedge ref_clk_in);
		#1;
		`GRFI_CHK("tx_er", 1'b1, tx_er_out)
		{tx_valid_in, tx_err_in} = 2'b00;
		@(posedge ref_clk_in);
		#1;
		`GRFI_CHK("tx_en idle", 1'b0, tx_en_out)
		`GRFI_CHK("tx_er idle", 1'b0, tx_er_out)
		`GRFI_CHK("txd idle", 8'h00, txd_out)
		$display("test tx done");
	end
	endtask : t_tx
	task automatic t_good;
	begin
		rx_frame(4, -1, 1'b0, grfi_pkg::PREAMBLE_BYTE);
		`GRFI_CHK("bytes", 4, got_q.size())
		for (i = 0; i < 4; i++)
			`GRFI_CHK("rx data", 8'h10 + 8'(i), got_q[i])
		`GRFI_CHK("bursts", 1, rises)
		`GRFI_CHK("eofs", 1, eofs)
		`GRFI_CHK("rx_error", 1'b0, err_s)
		`GRFI_CHK("stat", {16'h0004, 13'h0000, 3'b000}, stat_s)
		$display("test good frame done");
	end
	endtask : t_good
	task automatic t_err_full;
	begin
		rx_frame(3, 2, 1'b0, grfi_pkg::PREAMBLE_BYTE);
		`GRFI_CHK("rx_error", 1'b1, err_s)
		`GRFI_CHK("stat err", {16'h0003, 13'h0000, 3'b001}, stat_s)
		rx_frame(2, -1, 1'b1, grfi_pkg::PREAMBLE_BYTE);
		`GRFI_CHK("fifo_error", 1'b1, ferr_s)
		`GRFI_CHK("ovf flag", 3'b010, stat_s[2:0])
		`GRFI_CHK("eofs", 1, eofs)
		$display("test errors done");
	end
	endtask : t_err_full
	task automatic t_drop_bad;
	begin
		drop_pkts_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		rx_frame(3, -1, 1'b0, grfi_pkg::PREAMBLE_BYTE);
		drop_pkts_in = 1'b0;
		`GRFI_CHK("drop writes", 0, got_q.size())
		`GRFI_CHK("drop eofs", 0, eofs)
		`GRFI_CHK("drop flag", 3'b100, stat_s[2:0])
		repeat (3) @(posedge ref_clk_in);
		rx_frame(3, -1, 1'b0, 8'h5A);
		`GRFI_CHK("bad lead writes", 0, got_q.size())
		`GRFI_CHK("bad lead stats", 0, stats)
		$display("test drop done");
	end
	endtask : t_drop_bad
	task automatic t_b2b;
	begin
		got_q.delete();
		{eofs, stats, rises} = '0;
		i_grfi_phy_model.send(2, -1, 1'b0, grfi_pkg::PREAMBLE_BYTE);
		i_grfi_phy_model.send(1, -1, 1'b0, grfi_pkg::PREAMBLE_BYTE);
		repeat (4) @(posedge ref_clk_in);
		#1;
		`GRFI_CHK("b2b eofs", 2, eofs)
		`GRFI_CHK("b2b stats", 2, stats)
		`GRFI_CHK("b2b bytes", 3, got_q.size())
		`GRFI_CHK("b2b bursts", 2, rises)
		`GRFI_CHK("b2b last", {16'h0001, 13'h0000, 3'b000}, stat_s)
		$display("test back to back done");
	end
	endtask : t_b2b
	task automatic report_and_stop;
	begin
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask : report_and_stop
	initial
	begin
		repeat (5) @(posedge ref_clk_in);
		#1;
		srst_in = 1'b0;
		t_tx();
		t_good();
		t_err_full();
		t_drop_bad();
		t_b2b();
		report_and_stop();
	end
	// Whole run is under a hundred cycles; this leaves ample margin
	initial
	begin
		#20000;
		fails++;
		report_and_stop();
	end
endmodule : grfi_mac_edge_bench
`default_nettype wire
